// ---- hw/pcs_pkg.sv ----
package pcs_pkg;
  localparam int MULT_W = 7;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STRAP_W = 2;
  localparam int SDR_W = 3;
  localparam int PD_W = 2;
  localparam int REF_CNT_W = 13;

  // register byte addresses
  localparam logic [7:0] ADDR_POWER_MGMT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // power_mgmt_control fields
  localparam int PM_MULT_LSB = 0;
  localparam int PM_PD_LSB = 7;
  localparam int PM_HALVE_BIT = 9;
  localparam int PM_SDR_LSB = 10;

  // status fields
  localparam int ST_HOLD_BIT = 0;
  localparam int ST_EXT_BIT = 1;
  localparam int ST_STRAP_LSB = 2;
  localparam int ST_CNT_LSB = 4;

  // reset values and ratio constants
  localparam logic [6:0] MULT_RST = 7'h10;
  localparam logic [1:0] PD_CODE_2 = 2'h0;
  localparam logic [2:0] SDR_RST = 3'h2;
  localparam logic [2:0] SDR_ONE = 3'h1;
  localparam logic [2:0] SDR_TWO = 3'h2;
  localparam logic [4:0] PD_BASE = 5'h02;

  // multiplier loaded from each strap setting
  localparam logic [6:0] STRAP_MULT0 = 7'h08;
  localparam logic [6:0] STRAP_MULT1 = 7'h10;
  localparam logic [6:0] STRAP_MULT2 = 7'h20;
  localparam logic [6:0] STRAP_MULT3 = 7'h10;
  localparam logic [1:0] STRAP_SEL0 = 2'h0;
  localparam logic [1:0] STRAP_SEL1 = 2'h1;
  localparam logic [1:0] STRAP_SEL2 = 2'h2;

  // core reset hold: reference edges, then core cycles
  localparam logic [12:0] REF_HOLD_CYCLES = 13'h1000;
  localparam logic [1:0] CORE_HOLD_CYCLES = 2'h2;
  localparam logic [1:0] CORE_CNT_ONE = 2'h1;

  typedef enum logic [1:0] {PCS_S_EXT, PCS_S_REF, PCS_S_CORE, PCS_S_RUN} pcs_state_t;
endpackage

// ---- hw/pcs_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;
  logic [W-1:0] pinOut_reg;
  logic [W-1:0] agree;

  // a bit counts only once stages two and three agree
  assign agree = ~(stage2_reg ^ stage3_reg);

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
      stage3_reg <= INIT;
      pinOut_reg <= INIT;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      pinOut_reg <= (agree & stage3_reg) | (~agree & pinOut_reg);
    end
  end

  assign pinOut = pinOut_reg;
endmodule
`default_nettype wire

// ---- hw/pll_clock_reset_sequencer.sv ----
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_reset_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic referenceClockIn,
  input wire logic [pcs_pkg::STRAP_W-1:0] ratioSelectStraps,
  input wire logic [pcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pcs_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [pcs_pkg::DATA_W-1:0] regRdata,
  output logic coreResetHold,
  output logic periphTick,
  output logic sdramTick,
  output logic [pcs_pkg::MULT_W:0] vcoMultiplier,
  output logic [5:0] coreDivisor
);
  // mclk is the core clock itself; ratios are exported for the loop
  logic extResetN;
  logic refSync;
  logic [pcs_pkg::STRAP_W-1:0] strapSync;
  logic extActive;
  logic refPrev_reg;
  logic refRise;

  // pin sampling may add one reference cycle to the hold
  pcs_pin_sync #(.W(1), .INIT(1'b0)) uResetSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(resetPinN),
    .pinOut(extResetN)
  );

  pcs_pin_sync #(.W(1), .INIT(1'b0)) uRefSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(referenceClockIn),
    .pinOut(refSync)
  );

  // straps only matter while the pin holds reset
  pcs_pin_sync #(.W(pcs_pkg::STRAP_W), .INIT('0)) uStrapSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn(ratioSelectStraps),
    .pinOut(strapSync)
  );

  assign extActive = ~extResetN;
  assign refRise = refSync & ~refPrev_reg;

  // power_mgmt_control
  logic [pcs_pkg::MULT_W-1:0] loopMult_reg;
  logic [pcs_pkg::MULT_W-1:0] loopMult_next;
  logic [pcs_pkg::PD_W-1:0] postDivCode_reg;
  logic [pcs_pkg::PD_W-1:0] postDivCode_next;
  logic halve_reg;
  logic halve_next;
  logic [pcs_pkg::SDR_W-1:0] sdrRatio_reg;
  logic [pcs_pkg::SDR_W-1:0] sdrRatio_next;
  logic [pcs_pkg::MULT_W-1:0] strapMultiplier;
  logic pmWrite;

  assign strapMultiplier =
    (strapSync == pcs_pkg::STRAP_SEL0) ? pcs_pkg::STRAP_MULT0 :
    (strapSync == pcs_pkg::STRAP_SEL1) ? pcs_pkg::STRAP_MULT1 :
    (strapSync == pcs_pkg::STRAP_SEL2) ? pcs_pkg::STRAP_MULT2 : pcs_pkg::STRAP_MULT3;

  assign pmWrite = regWrite && (regAddr == pcs_pkg::ADDR_POWER_MGMT_CONTROL);
  // writes during external reset are dropped: reset owns the loop settings
  assign loopMult_next = extActive ? strapMultiplier :
    pmWrite ? regWdata[pcs_pkg::PM_MULT_LSB +: pcs_pkg::MULT_W] : loopMult_reg;
  assign postDivCode_next = extActive ? pcs_pkg::PD_CODE_2 :
    pmWrite ? regWdata[pcs_pkg::PM_PD_LSB +: pcs_pkg::PD_W] : postDivCode_reg;
  assign halve_next = (pmWrite && !extActive) ? regWdata[pcs_pkg::PM_HALVE_BIT] : halve_reg;
  assign sdrRatio_next = (pmWrite && !extActive) ?
    regWdata[pcs_pkg::PM_SDR_LSB +: pcs_pkg::SDR_W] : sdrRatio_reg;

  // sequencer
  pcs_pkg::pcs_state_t state_reg;
  pcs_pkg::pcs_state_t state_next;
  logic [pcs_pkg::REF_CNT_W-1:0] refCnt_reg;
  logic [pcs_pkg::REF_CNT_W-1:0] refCnt_next;
  logic [1:0] coreCnt_reg;
  logic [1:0] coreCnt_next;
  logic coreHold_reg;
  logic refDone;

  assign refDone = refRise && (refCnt_reg == pcs_pkg::REF_HOLD_CYCLES - 13'h0001);

  always_comb begin
    state_next = state_reg;
    refCnt_next = refCnt_reg;
    coreCnt_next = coreCnt_reg;
    case (state_reg)
      pcs_pkg::PCS_S_EXT: begin
        refCnt_next = '0;
        if (!extActive) begin
          state_next = pcs_pkg::PCS_S_REF;
        end
      end
      pcs_pkg::PCS_S_REF: begin
        if (refRise) begin
          refCnt_next = refCnt_reg + 13'h0001;
        end
        coreCnt_next = '0;
        if (refDone) begin
          state_next = pcs_pkg::PCS_S_CORE;
        end
      end
      pcs_pkg::PCS_S_CORE: begin
        coreCnt_next = coreCnt_reg + 2'h1;
        if (coreCnt_reg == pcs_pkg::CORE_HOLD_CYCLES - pcs_pkg::CORE_CNT_ONE) begin
          state_next = pcs_pkg::PCS_S_RUN;
        end
      end
      default: begin
        state_next = pcs_pkg::PCS_S_RUN;
      end
    endcase
    // a reset mid-count must restart from zero, not resume
    if (extActive) begin
      state_next = pcs_pkg::PCS_S_EXT;
      refCnt_next = '0;
      coreCnt_next = '0;
    end
  end

  // derived clocks
  logic periphPhase_reg;
  logic periphTick_reg;
  logic [pcs_pkg::SDR_W-1:0] sdrCnt_reg;
  logic [pcs_pkg::SDR_W-1:0] sdrCnt_next;
  logic [pcs_pkg::SDR_W-1:0] sdrRatioEff;
  logic sdrWrap;
  logic sdramTick_reg;

  // a zero ratio is treated as one rather than stalling the sdram clock
  assign sdrRatioEff = (sdrRatio_reg == '0) ? pcs_pkg::SDR_ONE : sdrRatio_reg;
  assign sdrWrap = (sdrCnt_reg >= sdrRatioEff - pcs_pkg::SDR_ONE);
  assign sdrCnt_next = (coreHold_reg || sdrWrap) ? '0 : sdrCnt_reg + pcs_pkg::SDR_ONE;

  // loop ratio outputs
  logic [pcs_pkg::MULT_W:0] vco_reg;
  logic [5:0] coreDiv_reg;
  logic [4:0] postDivVal;

  assign postDivVal = pcs_pkg::PD_BASE << postDivCode_reg;

  // register read
  logic [pcs_pkg::DATA_W-1:0] pmValue;
  logic [pcs_pkg::DATA_W-1:0] stValue;
  logic [pcs_pkg::DATA_W-1:0] readMux;
  logic [pcs_pkg::DATA_W-1:0] rdata_reg;

  assign pmValue = {19'h0, sdrRatio_reg, halve_reg, postDivCode_reg, loopMult_reg};
  assign stValue = {15'h0, refCnt_reg, strapSync, extActive, coreHold_reg};
  assign readMux = (regAddr == pcs_pkg::ADDR_POWER_MGMT_CONTROL) ? pmValue :
                   (regAddr == pcs_pkg::ADDR_STATUS) ? stValue : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      refPrev_reg <= 1'b0;
      loopMult_reg <= pcs_pkg::MULT_RST;
      postDivCode_reg <= pcs_pkg::PD_CODE_2;
      halve_reg <= 1'b0;
      sdrRatio_reg <= pcs_pkg::SDR_RST;
      state_reg <= pcs_pkg::PCS_S_EXT;
      refCnt_reg <= '0;
      coreCnt_reg <= '0;
      coreHold_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      refPrev_reg <= refSync;
      loopMult_reg <= loopMult_next;
      postDivCode_reg <= postDivCode_next;
      halve_reg <= halve_next;
      sdrRatio_reg <= sdrRatio_next;
      state_reg <= state_next;
      refCnt_reg <= refCnt_next;
      coreCnt_reg <= coreCnt_next;
      coreHold_reg <= (state_next != pcs_pkg::PCS_S_RUN);
      rdata_reg <= regRead ? readMux : '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      periphPhase_reg <= 1'b0;
      periphTick_reg <= 1'b0;
      sdrCnt_reg <= '0;
      sdramTick_reg <= 1'b0;
      vco_reg <= '0;
      coreDiv_reg <= '0;
    end else begin
      periphPhase_reg <= coreHold_reg ? 1'b0 : ~periphPhase_reg;
      periphTick_reg <= !coreHold_reg && periphPhase_reg;
      sdrCnt_reg <= sdrCnt_next;
      sdramTick_reg <= !coreHold_reg && sdrWrap;
      vco_reg <= {loopMult_reg, 1'b0};
      coreDiv_reg <= halve_reg ? {postDivVal, 1'b0} : {1'b0, postDivVal};
    end
  end

  assign regRdata = rdata_reg;
  assign coreResetHold = coreHold_reg;
  assign periphTick = periphTick_reg;
  assign sdramTick = sdramTick_reg;
  assign vcoMultiplier = vco_reg;
  assign coreDivisor = coreDiv_reg;

  chk_postdiv_reset: assert property (@(posedge mclk) disable iff (rst)
    extActive |=> (postDivCode_reg == pcs_pkg::PD_CODE_2))
    else $error("post divider not forced during reset");

  chk_mult_strap: assert property (@(posedge mclk) disable iff (rst)
    extActive |=> loopMult_reg == $past(strapMultiplier))
    else $error("multiplier not loaded from straps");

  chk_vco_ratio: assert property (@(posedge mclk) disable iff (rst)
    $stable(loopMult_reg) |=> vcoMultiplier == {$past(loopMult_reg), 1'b0})
    else $error("oscillator ratio is not twice the multiplier");

  chk_input_halve: assert property (@(posedge mclk) disable iff (rst)
    (halve_reg && postDivCode_reg == pcs_pkg::PD_CODE_2) |=> coreDivisor == 6'h04)
    else $error("input halving not reflected in core divisor");

  chk_periph_period: assert property (@(posedge mclk) disable iff (rst)
    (periphTick && !coreHold_reg && !extActive) |=> !periphTick ##1 (periphTick || coreHold_reg))
    else $error("peripheral tick not every two core cycles");

  chk_sdram_period: assert property (@(posedge mclk) disable iff (rst)
    (sdramTick && !coreHold_reg && !extActive && sdrRatio_reg == pcs_pkg::SDR_TWO && !regWrite)
    |=> !sdramTick ##1 (sdramTick || coreHold_reg || $past(regWrite)))
    else $error("sdram tick not at programmed ratio");

  chk_core_two_cycles: assert property (@(posedge mclk) disable iff (rst || extActive)
    (state_reg == pcs_pkg::PCS_S_REF && refDone) |=> coreHold_reg ##1 coreHold_reg ##1 !coreHold_reg)
    else $error("core reset not released two core cycles after count");

  chk_ref_count: assert property (@(posedge mclk) disable iff (rst)
    $fell(coreHold_reg) |-> refCnt_reg == pcs_pkg::REF_HOLD_CYCLES)
    else $error("core reset released before full reference count");

  chk_hold_in_reset: assert property (@(posedge mclk) disable iff (rst)
    extActive |=> coreHold_reg && refCnt_reg == '0)
    else $error("core reset not held while reset pin asserted");
endmodule
`default_nettype wire

// ---- bench/pcs_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcs_board_model #(
  parameter int REF_HALF = 4,
  parameter int SETUP_REF = 20
) (
  input wire logic mclk,
  input wire logic holdReset,
  input wire logic [1:0] strapIn,
  output logic resetPinN,
  output logic referenceClockIn,
  output logic [1:0] ratioSelectStraps
);
  int halfCnt = 0;
  int lowRefs = 0;
  initial begin
    resetPinN = 1'b0;
    referenceClockIn = 1'b0;
    ratioSelectStraps = 2'h0;
  end
  // oscillator free-runs from time zero, long valid before any release
  always @(posedge mclk) begin
    halfCnt <= (halfCnt == REF_HALF - 1) ? 0 : halfCnt + 1;
    if (halfCnt == REF_HALF - 1) referenceClockIn <= ~referenceClockIn;
  end
  // a strap change restarts the setup count; release only as the reference falls
  always @(posedge mclk) begin
    if (resetPinN) lowRefs <= 0;
    else if (ratioSelectStraps != strapIn) begin
      ratioSelectStraps <= strapIn;
      lowRefs <= 0;
    end else if (halfCnt == REF_HALF - 1 && !referenceClockIn) lowRefs <= lowRefs + 1;
    if (holdReset) resetPinN <= 1'b0;
    else if (lowRefs >= SETUP_REF && halfCnt == REF_HALF - 1 && referenceClockIn) begin
      resetPinN <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/pll_clock_reset_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_clock_reset_sequencer_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic holdReset = 1'b1;
  logic [1:0] strapIn = 2'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  wire logic resetPinN, refClk, coreResetHold, periphTick, sdramTick;
  wire logic [1:0] straps;
  wire logic [31:0] regRdata;
  wire logic [7:0] vcoMultiplier;
  wire logic [5:0] coreDivisor;
  int nErrors = 0, totalChecks = 0, cyc = 0, n, m, pd, hv, sd;
  int strapMult[4] = '{8, 16, 32, 16};
  logic [31:0] rd;
  // ratio ceilings stand in for the oscillator limit; direct input allows half
  localparam int MULT_MAX_HALVED = 127;
  localparam int MULT_MAX_DIRECT = 63;
  always #4 mclk = ~mclk;
  pcs_board_model u_pcs_board_model (.mclk(mclk), .holdReset(holdReset), .strapIn(strapIn),
    .resetPinN(resetPinN), .referenceClockIn(refClk), .ratioSelectStraps(straps));
  pll_clock_reset_sequencer u_pll_clock_reset_sequencer (.mclk(mclk), .rst(rst),
    .resetPinN(resetPinN), .referenceClockIn(refClk), .ratioSelectStraps(straps),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .coreResetHold(coreResetHold), .periphTick(periphTick),
    .sdramTick(sdramTick), .vcoMultiplier(vcoMultiplier), .coreDivisor(coreDivisor));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkN(input string what, input int e, input int g);
    totalChecks++;
    if (g != e) begin
      nErrors++;
      $display("unexpected %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    regRead <= 1'b1; regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask
  // bench model of the control word and the exported ratios
  task automatic chkCfg();
    rdr(8'h00);
    chk32("control word", 32'(m | pd << 7 | hv << 9 | sd << 10), rd);
    repeat (2) @(posedge mclk);
    #1 chk32("multiplier", 32'(2 * m), {24'h0, vcoMultiplier});
    chk32("divisor", 32'((2 << pd) * (hv + 1)), {26'h0, coreDivisor});
  endtask
  task automatic tickGap(output int g);
    g = 0;
    #1;
    while (sdramTick !== 1'b1 && g < 20) begin @(posedge mclk); #1 g++; end
    g = 0;
    do begin @(posedge mclk); #1 g++; end while (sdramTick !== 1'b1 && g < 20);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      nErrors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(96255));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    hv = 0; pd = 0; sd = 2;
    for (int s = 0; s < 4; s++) begin
      strapIn <= 2'(s);
      repeat (12) @(posedge mclk);
      m = strapMult[s];
      wr(8'h00, $urandom); // dropped while the pin holds reset
      chkCfg();
      rdr(8'h04);
      chk32("status in reset", 32'(3 | s << 2), rd);
    end
    $display("strap load test done");
    holdReset <= 1'b0;
    n = 0;
    while (resetPinN !== 1'b1 && n < 400) begin @(posedge mclk); #1 n++; end
    n = 0;
    while (coreResetHold !== 1'b0 && n < 33000) begin @(posedge mclk); #1 n++; end
    chkN("release in window", 1, int'(n >= 4096 * 8 && n <= 4097 * 8 + 10));
    rdr(8'h04);
    chk32("status running", 32'hc, rd & 32'hf);
    $display("release test done");
    n = 0;
    for (int i = 0; i < 16; i++) begin @(posedge mclk); #1 n += int'(periphTick === 1'b1); end
    chkN("peripheral ticks", 8, n);
    for (int r = 0; r < 8; r++) begin
      sd = r;
      wr(8'h00, 32'(m | sd << 10));
      repeat (4) @(posedge mclk);
      tickGap(n);
      chkN("sdram period", (r == 0) ? 1 : r, n);
    end
    $display("tick test done");
    for (int i = 0; i < 10; i++) begin
      hv = $urandom % 2;
      m = $urandom_range(hv ? MULT_MAX_HALVED : MULT_MAX_DIRECT, 1);
      pd = $urandom % 4;
      sd = $urandom % 8;
      wr(8'h00, 32'(m | pd << 7 | hv << 9 | sd << 10) | 32'hffff_e000);
      chkCfg();
    end
    m = 16;
    pd = 0;
    hv = 1;
    sd = 2;
    wr(8'h00, 32'(m | pd << 7 | hv << 9 | sd << 10));
    chkCfg();
    rdr(8'h08);
    chk32("unmapped read", 32'h0, rd);
    wr(8'h04, 32'hffff_ffff);
    rdr(8'h04);
    chk32("status after write", 32'hc, rd & 32'hf);
    $display("register test done");
    wr(8'h00, 32'h0);
    holdReset <= 1'b1;
    repeat (12) @(posedge mclk);
    holdReset <= 1'b0;
    repeat (200) @(posedge mclk);
    #1 chk32("hold mid count", 32'h1, {31'h0, coreResetHold});
    holdReset <= 1'b1;
    repeat (12) @(posedge mclk);
    rdr(8'h04);
    chk32("count restarted", 32'hf, rd);
    #1 chk32("strap reload", 32'h20, {24'h0, vcoMultiplier});
    $display("restart test done");
    finish_test();
  end
endmodule
`default_nettype wire
